// file: src/flash_pkg.sv
// shared constants and types for the serial flash command front end and its host
package flash_pkg;
  // instruction codes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  // status byte layout
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_LEVEL_LO = 2;
  localparam int SR_LEVEL_HI = 4;
  localparam int SR_LOCK = 7;
  localparam logic [2:0] LEVEL_RESET = 3'h7;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [2:0] LEVEL_ALL = 3'h6;
  // array geometry: 32 blocks of 64 KB, address wraps at 2 MB
  localparam int ADDR_MSB = 20;
  localparam int BLK_LSB = 16;
  localparam logic [5:0] NUM_BLOCKS = 6'h20;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [8:0] PAGE_MAX_BYTES = 9'h100;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // pin vector positions after synchronising
  localparam int NPINS = 5;
  localparam int PIN_SCK = 0;
  localparam int PIN_CE = 1;
  localparam int PIN_HOLD = 2;
  localparam int PIN_WP = 3;
  localparam int PIN_SI = 4;
  localparam logic [NPINS-1:0] PINS_IDLE = 5'h0E;
  // internal operation times (typical) and their cycle counts
  localparam longint unsigned CLK_PERIOD_NS = 64'h4;
  localparam longint unsigned PAGE_PROG_TIME_NS = 64'd1500000;
  localparam longint unsigned SECTOR_ERASE_TIME_NS = 64'd90000000;
  localparam longint unsigned BLOCK_ERASE_TIME_NS = 64'd1000000000;
  localparam longint unsigned CHIP_ERASE_TIME_NS = 64'd10000000000;
  localparam int unsigned PAGE_PROG_CYCLES = 32'(PAGE_PROG_TIME_NS / CLK_PERIOD_NS);
  localparam int unsigned SECTOR_ERASE_CYCLES = 32'(SECTOR_ERASE_TIME_NS / CLK_PERIOD_NS);
  localparam int unsigned BLOCK_ERASE_CYCLES = 32'(BLOCK_ERASE_TIME_NS / CLK_PERIOD_NS);
  localparam int unsigned CHIP_ERASE_CYCLES = 32'(CHIP_ERASE_TIME_NS / CLK_PERIOD_NS);
  // host side: serial clock half period and register map
  localparam logic [7:0] SCK_HALF_CYCLES = 8'h10;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TX = 4'h4;
  localparam logic [3:0] REG_RX = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam int CTRL_CE = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_WP_LOW = 2;

  typedef enum logic [1:0] {CMD_SECTOR, CMD_BLOCK, CMD_CHIP, CMD_PROGRAM} cmd_kind_t;
endpackage : flash_pkg

// file: src/spi_link_if.sv
// serial link between host controller and flash front end
`timescale 1ns/100ps
interface spi_link_if;
  logic sck;
  logic ce_n;
  logic hold_n;
  logic wp_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic so_line;

  // undriven output line reads high
  assign so_line = so_oe_n ? 1'b1 : so;

  modport dev (input sck, input ce_n, input hold_n, input wp_n, input si,
               output so, output so_oe_n);
  modport host (output sck, output ce_n, output hold_n, output wp_n, output si,
                input so_line);
endinterface : spi_link_if

// file: src/flash_front.sv
// device end: serial command decode, block protection and hold handling
//
// Overview of operation
// - reject program/erase inside protected region
// - chip erase only when level is zero
// - protection level bits reset to ones
// - pin low and lock set freezes protection
// - pin high makes lock bit irrelevant
// - lock bit resets to zero
// - status write refused only pin low, lock
// - host keeps enable low while holding
// - enter pause at hold low, clock low
// - leave pause at hold high, clock low
// - paused: output off, input and clock ignored
// - enable rise while paused resets interface
// - writes need write enable latch set
// - sample rising clock, msb first, bytes
// - instruction starts at enable fall
// - enable rise mid byte aborts instruction
// - 20h plus address erases 4K sector
// - D8h plus address erases 64K block
// - 02h plus address, up to 256 bytes
// - level code selects top array portion
// - status bit0 busy, bit1 write latch
`timescale 1ns/100ps
module flash_front
  import flash_pkg::*;
#(
  parameter int unsigned PAGE_CYCLES = PAGE_PROG_CYCLES,
  parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int unsigned BLOCK_CYCLES = BLOCK_ERASE_CYCLES,
  parameter int unsigned CHIP_CYCLES = CHIP_ERASE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  spi_link_if.dev link,
  output logic cmd_valid,
  output cmd_kind_t cmd_kind,
  output logic [23:0] cmd_addr,
  output logic prog_valid,
  output logic [7:0] prog_byte,
  output logic rd_req,
  output logic [23:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic busy
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_STATUS,
    ST_PROG, ST_SRDATA, ST_DONE, ST_IGNORE
  } dev_st_t;

  typedef struct packed {
    logic [NPINS-1:0] s1;
    logic [NPINS-1:0] s2;
    logic [NPINS-1:0] s3;
    logic [NPINS-1:0] f;
    dev_st_t st;
    logic [2:0] bitcnt;
    logic [7:0] sr;
    logic [1:0] nbytes;
    logic [7:0] op;
    logic [23:0] addr;
    logic [8:0] prog_cnt;
    logic paused;
    logic write_enable_latch;
    logic busy;
    logic [31:0] busy_cnt;
    logic [2:0] level;
    logic lock;
    logic [7:0] out;
    logic so;
    logic so_oe_n;
    logic drive;
    logic cmd_valid;
    cmd_kind_t cmd_kind;
    logic [23:0] cmd_addr;
    logic prog_valid;
    logic [7:0] prog_byte;
    logic rd_req;
    logic [23:0] rd_addr;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;
  logic [NPINS-1:0] pins;

  assign pins = {link.si, link.wp_n, link.hold_n, link.ce_n, link.sck};

  // top portion of the array covered by the level code
  function automatic logic in_protected(input logic [2:0] lvl, input logic [23:0] a);
    logic [5:0] first;
    first = NUM_BLOCKS - (6'h01 << (lvl - 3'h1));
    if (lvl == LEVEL_NONE)
      return 1'b0;
    if (lvl >= LEVEL_ALL)
      return 1'b1;
    return {1'b0, a[ADDR_MSB:BLK_LSB]} >= first;
  endfunction : in_protected

  always_comb
  begin
    logic sck_rise;
    logic sck_fall;
    logic ce_rise;
    logic ce_fall;
    logic done;
    logic [7:0] rx;
    logic [7:0] status;
    logic [7:0] src;
    logic [23:0] full;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    ce_rise = 1'b0;
    ce_fall = 1'b0;
    done = 1'b0;
    rx = 8'h00;
    src = 8'h00;
    full = 24'h000000;
    status = 8'h00;
    d = q;
    d.cmd_valid = 1'b0;
    d.prog_valid = 1'b0;
    d.rd_req = 1'b0;
    // three stage synchronisers, a change counts once stages two and three agree
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < NPINS; i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.f[i] = q.s3[i];
    end
    sck_rise = d.f[PIN_SCK] & ~q.f[PIN_SCK];
    sck_fall = ~d.f[PIN_SCK] & q.f[PIN_SCK];
    ce_rise = d.f[PIN_CE] & ~q.f[PIN_CE];
    ce_fall = ~d.f[PIN_CE] & q.f[PIN_CE];
    status = {q.lock, 2'h0, q.level, q.write_enable_latch, q.busy};

    if (q.busy)
    begin
      if (q.busy_cnt == 32'h0)
        d.busy = 1'b0;
      else
        d.busy_cnt = q.busy_cnt - 32'h1;
    end

    // pause follows hold only while the clock is low
    if (d.f[PIN_CE])
      d.paused = q.paused & ~d.f[PIN_HOLD];
    else if (!d.f[PIN_SCK])
      d.paused = ~d.f[PIN_HOLD];

    if (ce_rise)
    begin
      if (q.bitcnt == 3'h0 && !q.paused)
      begin
        unique case (q.st)
          ST_DONE:
          begin
            if (q.op == OP_WRITE_ENABLE)
              d.write_enable_latch = 1'b1;
            else if (q.op == OP_WRITE_DISABLE)
              d.write_enable_latch = 1'b0;
            else if (q.op == OP_CHIP_ERASE_A || q.op == OP_CHIP_ERASE_B)
            begin
              if (q.write_enable_latch && q.level == LEVEL_NONE)
              begin
                d.cmd_valid = 1'b1;
                d.cmd_kind = CMD_CHIP;
                d.busy = 1'b1;
                d.busy_cnt = CHIP_CYCLES;
                d.write_enable_latch = 1'b0;
              end
            end
            else if (q.op == OP_SECTOR_ERASE || q.op == OP_BLOCK_ERASE)
            begin
              if (q.write_enable_latch && !in_protected(q.level, q.addr))
              begin
                d.cmd_valid = 1'b1;
                d.cmd_addr = q.addr;
                d.busy = 1'b1;
                d.write_enable_latch = 1'b0;
                if (q.op == OP_SECTOR_ERASE)
                begin
                  d.cmd_kind = CMD_SECTOR;
                  d.busy_cnt = SECTOR_CYCLES;
                end
                else
                begin
                  d.cmd_kind = CMD_BLOCK;
                  d.busy_cnt = BLOCK_CYCLES;
                end
              end
            end
            else if (q.op == OP_STATUS_WRITE)
            begin
              // lock only matters while the protect pin is low
              if (q.write_enable_latch && (q.f[PIN_WP] || !q.lock))
              begin
                d.level = q.addr[SR_LEVEL_HI:SR_LEVEL_LO];
                d.lock = q.addr[SR_LOCK];
                d.write_enable_latch = 1'b0;
              end
            end
          end
          ST_PROG:
          begin
            if (q.write_enable_latch && q.prog_cnt != 9'h0 && !in_protected(q.level, q.addr))
            begin
              d.cmd_valid = 1'b1;
              d.cmd_kind = CMD_PROGRAM;
              d.cmd_addr = q.addr;
              d.busy = 1'b1;
              d.busy_cnt = PAGE_CYCLES;
              d.write_enable_latch = 1'b0;
            end
          end
          default:
          begin
          end
        endcase
      end
      d.st = ST_IDLE;
      d.bitcnt = 3'h0;
      d.drive = 1'b0;
    end
    else if (ce_fall)
    begin
      d.st = ST_OPCODE;
      d.bitcnt = 3'h0;
      d.drive = 1'b0;
    end
    else if (!d.f[PIN_CE] && !d.paused)
    begin
      if (sck_rise)
      begin
        rx = {q.sr[6:0], d.f[PIN_SI]};
        d.sr = rx;
        d.bitcnt = q.bitcnt + 3'h1;
        done = (q.bitcnt == LAST_BIT);
      end
      if (sck_fall && (q.st == ST_READ || q.st == ST_STATUS))
      begin
        src = (q.st == ST_STATUS) ? status : rd_data;
        d.drive = 1'b1;
        if (q.bitcnt == 3'h0)
        begin
          d.so = src[7];
          d.out = {src[6:0], 1'b0};
        end
        else
        begin
          d.so = q.out[7];
          d.out = {q.out[6:0], 1'b0};
        end
      end
      if (done)
      begin
        unique case (q.st)
          ST_OPCODE:
          begin
            d.op = rx;
            d.nbytes = 2'h0;
            d.prog_cnt = 9'h0;
            if (rx == OP_STATUS_READ)
              d.st = ST_STATUS;
            else if (q.busy)
              d.st = ST_IGNORE;
            else if (rx == OP_READ || rx == OP_FAST_READ || rx == OP_SECTOR_ERASE ||
                     rx == OP_BLOCK_ERASE || rx == OP_PAGE_PROGRAM)
              d.st = ST_ADDR;
            else if (rx == OP_STATUS_WRITE)
              d.st = ST_SRDATA;
            else if (rx == OP_WRITE_ENABLE || rx == OP_WRITE_DISABLE ||
                     rx == OP_CHIP_ERASE_A || rx == OP_CHIP_ERASE_B)
              d.st = ST_DONE;
            else
              d.st = ST_IGNORE;
          end
          ST_ADDR:
          begin
            full = {q.addr[15:0], rx};
            d.addr = full;
            d.nbytes = q.nbytes + 2'h1;
            if (q.nbytes == ADDR_LAST_BYTE)
            begin
              if (q.op == OP_READ)
              begin
                d.st = ST_READ;
                d.rd_req = 1'b1;
                d.rd_addr = full;
                d.addr[ADDR_MSB:0] = full[ADDR_MSB:0] + 21'h1;
              end
              else if (q.op == OP_FAST_READ)
                d.st = ST_DUMMY;
              else if (q.op == OP_PAGE_PROGRAM)
                d.st = ST_PROG;
              else
                d.st = ST_DONE;
            end
          end
          ST_DUMMY, ST_READ:
          begin
            d.st = ST_READ;
            d.rd_req = 1'b1;
            d.rd_addr = q.addr;
            d.addr[ADDR_MSB:0] = q.addr[ADDR_MSB:0] + 21'h1;
          end
          ST_PROG:
          begin
            if (q.write_enable_latch && q.prog_cnt < PAGE_MAX_BYTES && !in_protected(q.level, q.addr))
            begin
              d.prog_valid = 1'b1;
              d.prog_byte = rx;
              d.prog_cnt = q.prog_cnt + 9'h1;
            end
          end
          ST_SRDATA:
          begin
            d.addr[7:0] = rx;
            d.st = ST_DONE;
          end
          default:
          begin
          end
        endcase
      end
    end
    // output turns on at the first clock fall of the data phase, never while clock is high
    d.so_oe_n = ~(d.drive & ~d.paused & ~d.f[PIN_CE]);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.s1 <= PINS_IDLE;
      q.s2 <= PINS_IDLE;
      q.s3 <= PINS_IDLE;
      q.f <= PINS_IDLE;
      q.level <= LEVEL_RESET;
      q.lock <= LOCK_RESET;
      q.so_oe_n <= 1'b1;
    end
    else
      q <= d;
  end

  assign link.so = q.so;
  assign link.so_oe_n = q.so_oe_n;
  assign cmd_valid = q.cmd_valid;
  assign cmd_kind = q.cmd_kind;
  assign cmd_addr = q.cmd_addr;
  assign prog_valid = q.prog_valid;
  assign prog_byte = q.prog_byte;
  assign rd_req = q.rd_req;
  assign rd_addr = q.rd_addr;
  assign busy = q.busy;
endmodule : flash_front

// file: src/flash_host.sv
// host end: byte-wide serial master steered through a small register port
`timescale 1ns/100ps
module flash_host
  import flash_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  spi_link_if.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  typedef struct packed {
    logic [2:0] so_s;
    logic so_f;
    logic [2:0] ctrl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] bits;
    logic active;
    logic [7:0] div;
    logic sck;
    logic ce_n;
    logic hold_n;
    logic wp_n;
    logic si;
    logic [7:0] rdata;
  } host_state_t;

  host_state_t q;
  host_state_t d;

  always_comb
  begin
    d = q;
    d.so_s = {q.so_s[1:0], link.so_line};
    if (q.so_s[1] == q.so_s[2])
      d.so_f = q.so_s[2];
    d.rdata = 8'h00;
    if (reg_wr && reg_addr == REG_CTRL)
      d.ctrl = reg_wdata[2:0];
    if (reg_wr && reg_addr == REG_TX && !q.active)
    begin
      d.tx = reg_wdata;
      d.si = reg_wdata[7];
      d.active = 1'b1;
      d.bits = 3'h0;
      d.div = 8'h00;
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL: d.rdata = {5'h00, q.ctrl};
        REG_RX: d.rdata = q.rx;
        REG_STAT: d.rdata = {7'h00, q.active};
        default: d.rdata = 8'h00;
      endcase
    end
    d.ce_n = ~d.ctrl[CTRL_CE];
    d.hold_n = ~(d.ctrl[CTRL_HOLD] & d.ctrl[CTRL_CE]);
    d.wp_n = ~d.ctrl[CTRL_WP_LOW];
    // clock stands still while holding
    if (q.active && q.hold_n && !(reg_wr && reg_addr == REG_TX))
    begin
      if (q.div == SCK_HALF_CYCLES - 8'h01)
      begin
        d.div = 8'h00;
        if (!q.sck)
        begin
          d.sck = 1'b1;
          d.rx = {q.rx[6:0], q.so_f};
        end
        else
        begin
          d.sck = 1'b0;
          d.tx = {q.tx[6:0], 1'b0};
          d.si = q.tx[6];
          d.bits = q.bits + 3'h1;
          if (q.bits == LAST_BIT)
            d.active = 1'b0;
        end
      end
      else
        d.div = q.div + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.so_s <= 3'h7;
      q.so_f <= 1'b1;
      q.ce_n <= 1'b1;
      q.hold_n <= 1'b1;
      q.wp_n <= 1'b1;
    end
    else
      q <= d;
  end

  assign link.sck = q.sck;
  assign link.ce_n = q.ce_n;
  assign link.hold_n = q.hold_n;
  assign link.wp_n = q.wp_n;
  assign link.si = q.si;
  assign reg_rdata = q.rdata;
endmodule : flash_host

// file: tb/flash_link_assertions.sv
// link-level checks between the flash host end and the flash front end
`timescale 1ns/100ps
module flash_link_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sck,
  input wire logic ce_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);

  ce_idle_off_a: assert property (ce_n [*6] |-> so_oe_n)
    else $error("serial output driven while deselected");
  hold_off_a: assert property ((!hold_n && !sck && !ce_n) [*8] |-> so_oe_n)
    else $error("serial output driven while paused");
  so_on_fall_a: assert property (!so_oe_n && $changed(so) |-> !sck)
    else $error("serial output changed while clock high");
  oe_start_a: assert property ($fell(so_oe_n) |-> !sck && !ce_n)
    else $error("output enabled outside a selected low clock phase");
  ce_start_a: assert property ($fell(ce_n) |-> !sck && hold_n)
    else $error("frame started with clock high or in pause");
  si_stable_a: assert property (sck && $past(sck) |-> $stable(si))
    else $error("serial input moved while clock high");
  hold_ce_a: assert property ($fell(hold_n) |-> !ce_n)
    else $error("pause requested without chip enable");
  sck_freeze_a: assert property (!hold_n && !$past(hold_n) |-> $stable(sck))
    else $error("serial clock moved during pause");

  cover property ($fell(so_oe_n));
  cover property (!hold_n && !ce_n);
  cover property (!wp_n && $fell(ce_n));
endmodule : flash_link_assertions

// file: tb/testbench.sv
// self-checking bench: host register port drives the flash front end over the link
`timescale 1ns/100ps
module testbench;
  import flash_pkg::*;
  logic mclk;
  logic rst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic cmd_valid;
  cmd_kind_t cmd_kind;
  logic [23:0] cmd_addr;
  logic prog_valid;
  logic [7:0] prog_byte;
  logic rd_req;
  logic [23:0] rd_addr;
  logic [7:0] rd_data;
  logic busy;
  logic [7:0] ctrl_wp;
  logic [7:0] rxb [0:7];
  int err_count;
  int checked;
  int cycles = 0;
  int cmds = 0;
  int progs = 0;
  int p0;

  spi_link_if link ();
  flash_host u_flash_host (.mclk(mclk), .rst(rst), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  flash_front #(.PAGE_CYCLES(40), .SECTOR_CYCLES(2000), .BLOCK_CYCLES(40), .CHIP_CYCLES(40))
    u_flash_front (.mclk(mclk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .prog_valid(prog_valid), .prog_byte(prog_byte),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
  flash_link_assertions u_flash_link_assertions (.mclk(mclk), .rst(rst), .sck(link.sck),
    .ce_n(link.ce_n), .hold_n(link.hold_n), .wp_n(link.wp_n), .si(link.si), .so(link.so),
    .so_oe_n(link.so_oe_n));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // array stand-in: each byte is its low address bits scrambled
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    rd_data <= rd_addr[7:0] ^ 8'h3C;
    if (cmd_valid === 1'b1)
      cmds <= cmds + 1;
    if (prog_valid === 1'b1)
      progs <= progs + 1;
    if (cycles == 80000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic reg_write(logic [3:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic wait_shift();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++)
      reg_read(REG_STAT, s);
  endtask : wait_shift

  task automatic xfer(logic [7:0] tx, output logic [7:0] rx);
    reg_write(REG_TX, tx);
    wait_shift();
    reg_read(REG_RX, rx);
  endtask : xfer

  task automatic wait_idle();
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge mclk);
  endtask : wait_idle

  // pause between bytes, output must float, then resume
  task automatic hold_pause();
    reg_write(REG_CTRL, ctrl_wp | 8'h03);
    repeat (16) @(posedge mclk);
    check("paused output enable", 32'h1, link.so_oe_n);
    reg_write(REG_CTRL, ctrl_wp | 8'h01);
    repeat (8) @(posedge mclk);
  endtask : hold_pause

  task automatic frame(int n, logic [63:0] b, int hold_at = -1, bit keep_ce = 1'b0);
    reg_write(REG_CTRL, ctrl_wp | 8'h01);
    for (int i = 0; i < n; i++)
    begin
      if (i == hold_at)
        hold_pause();
      xfer(b[63-8*i -: 8], rxb[i]);
    end
    if (!keep_ce)
      reg_write(REG_CTRL, ctrl_wp);
    repeat (12) @(posedge mclk);
  endtask : frame

  task automatic stat_is(logic [7:0] e);
    frame(2, {OP_STATUS_READ, 56'h0});
    check("status byte", e, rxb[1]);
  endtask : stat_is

  task automatic write_enable_instr();
    wait_idle();
    frame(1, {OP_WRITE_ENABLE, 56'h0});
  endtask : write_enable_instr

  task automatic status_write_instr(logic [7:0] v);
    write_enable_instr();
    frame(2, {OP_STATUS_WRITE, v, 48'h0});
  endtask : status_write_instr

  task automatic expect_cmd(bit we, int nb, logic [63:0] b, int n, cmd_kind_t k);
    int c0;
    wait_idle();
    if (we)
      write_enable_instr();
    c0 = cmds;
    frame(nb, b);
    check("command count", c0 + n, cmds);
    if (n == 1)
      check("command kind", k, cmd_kind);
    if (n == 1 && k != CMD_CHIP)
      check("command address", b[55:32], cmd_addr);
  endtask : expect_cmd

  initial
  begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctrl_wp = 8'h00;
    err_count = 0;
    checked = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    stat_is(8'h1C);
    write_enable_instr();
    stat_is(8'h1E);
    status_write_instr(8'h84);
    stat_is(8'h84);
    ctrl_wp = 8'h04;
    status_write_instr(8'h00);
    stat_is(8'h86);
    frame(1, {OP_WRITE_DISABLE, 56'h0});
    stat_is(8'h84);
    ctrl_wp = 8'h00;
    status_write_instr(8'h00);
    stat_is(8'h00);
    ctrl_wp = 8'h04;
    status_write_instr(8'h04);
    stat_is(8'h04);
    ctrl_wp = 8'h00;
    expect_cmd(1, 4, {OP_SECTOR_ERASE, 24'h1F0000, 32'h0}, 0, CMD_SECTOR);
    expect_cmd(1, 4, {OP_SECTOR_ERASE, 24'h1EF123, 32'h0}, 1, CMD_SECTOR);
    stat_is(8'h05);
    expect_cmd(1, 1, {OP_CHIP_ERASE_A, 56'h0}, 0, CMD_CHIP);
    status_write_instr(8'h00);
    expect_cmd(0, 6, {OP_PAGE_PROGRAM, 24'h000010, 32'hA53C_0000}, 0, CMD_PROGRAM);
    expect_cmd(1, 4, {OP_BLOCK_ERASE, 24'h0A1234, 32'h0}, 1, CMD_BLOCK);
    expect_cmd(1, 1, {OP_CHIP_ERASE_A, 56'h0}, 1, CMD_CHIP);
    expect_cmd(1, 1, {OP_CHIP_ERASE_B, 56'h0}, 1, CMD_CHIP);
    p0 = progs;
    expect_cmd(1, 6, {OP_PAGE_PROGRAM, 24'h000010, 32'hA53C_0000}, 1, CMD_PROGRAM);
    check("program byte count", p0 + 2, progs);
    check("last program byte", 32'h3C, prog_byte);
    // enable released in the middle of the second program data byte
    write_enable_instr();
    p0 = cmds;
    frame(5, {OP_PAGE_PROGRAM, 24'h000020, 8'h5A, 24'h0}, -1, 1'b1);
    reg_write(REG_TX, 8'h10);
    repeat (60) @(posedge mclk);
    reg_write(REG_CTRL, 8'h00);
    wait_shift();
    repeat (12) @(posedge mclk);
    check("aborted command count", p0, cmds);
    // enable raised while paused after a whole chip erase opcode
    reg_write(REG_CTRL, 8'h01);
    xfer(OP_CHIP_ERASE_A, rxb[0]);
    reg_write(REG_CTRL, 8'h03);
    repeat (16) @(posedge mclk);
    reg_write(REG_CTRL, 8'h00);
    repeat (12) @(posedge mclk);
    check("paused command count", p0, cmds);
    stat_is(8'h02);
    frame(7, {OP_READ, 24'h000102, 32'h0}, 5);
    check("read first byte", 32'h3E, rxb[4]);
    check("read after pause", 32'h3F, rxb[5]);
    check("read third byte", 32'h38, rxb[6]);
    frame(6, {OP_FAST_READ, 24'h000200, 32'h0});
    check("fast read byte", 32'h3C, rxb[5]);
    end_of_test();
  end
endmodule : testbench
